// *** verilog/iwu_consts.svh ***
// Offsets, field positions and reset values of the interrupt and wake unit
`ifndef IWU_CONSTS_SVH
`define IWU_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define IWU_OFS_FLAGS 8'h00
`define IWU_OFS_MASK 8'h01
`define IWU_OFS_POWER 8'h02
`define IWU_OFS_OSC 8'h03
`define IWU_OFS_WAKE 8'h04
`define IWU_OFS_CH1_LO 8'h10
`define IWU_OFS_CH1_HI 8'h11
`define IWU_OFS_CH2_LO 8'h12
`define IWU_OFS_CH2_HI 8'h13

// ****************************************************************
// Field positions
// ****************************************************************
`define IWU_BIT_TIMER 0
`define IWU_BIT_EP0 1
`define IWU_BIT_SUSPEND 2
`define IWU_BIT_USB_RESET 3
`define IWU_BIT_PORT7 4
`define IWU_BIT_CH1 5
`define IWU_BIT_CH2 6
`define IWU_BIT_HOST_RESUME 7
`define IWU_BIT_RUN 4
`define IWU_BIT_DUAL_CLK 7
`define IWU_BIT_PAT_EN 2
`define IWU_BIT_SLOW_LO 6
`define IWU_BIT_SLOW_HI 7
`define IWU_BIT_RESUME_WAKE 3

// ****************************************************************
// Values
// ****************************************************************
`define IWU_ZERO8 8'h00
`define IWU_SAT_COUNT 8'hff
`define IWU_VECTOR_ADDR 13'h0001
`define IWU_RESET_MASK 8'h00
`define IWU_RESET_RUN 1'b1
`define IWU_RESET_DUAL_CLK 1'b1

`endif

// *** verilog/iwu_pkg.sv ***
// Types shared by the interrupt and wake unit
`default_nettype none
package iwu_pkg;

    typedef logic [7:0] iwu_byte_t;
    typedef logic [7:0] iwu_addr_t;
    typedef logic [12:0] iwu_pc_t;

    // ****************************************************************
    // State of one pattern channel watcher
    // ****************************************************************
    typedef struct packed {
        logic prev_level;
        logic [7:0] prev_count;
        logic primed;
    } iwu_chan_t;

    // ****************************************************************
    // State of the top level
    // ****************************************************************
    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] mask;
        logic [7:0] ch1_lo;
        logic [7:0] ch1_hi;
        logic [7:0] ch2_lo;
        logic [7:0] ch2_hi;
        logic run;
        logic dual_clk;
        logic pat_en;
        logic [1:0] slow_freq;
        logic resume_wake;
        logic gie;
        logic vec_req;
        logic [12:0] vec_addr;
        logic [7:0] rdata;
        logic [7:0] port7_prev;
        logic port7_primed;
    } iwu_state_t;

endpackage : iwu_pkg
`default_nettype wire

// *** verilog/iwu_wake_unit.sv ***
// Interrupt status, masking, vectoring and power-down wake logic
//
// How it works
// - A taken interrupt requests a jump to the single vector address 0x0001.
// - Free timer counter overflow sets status bit 0.
// - Any level change on port 7 sets status bit 4.
// - Channel one edge with count above matching threshold sets bit 5.
// - Channel one held steady until count saturates also sets bit 5.
// - Channel two edge with count above matching threshold sets bit 6.
// - Channel two held steady until count saturates also sets bit 6.
// - Accepted setup transaction to endpoint zero sets status bit 1.
// - Bus suspend detection sets status bit 2.
// - Bus reset detection sets status bit 3.
// - Leaving suspend without own device resume sets status bit 7.
// - Mask bit zero blocks vectoring; status still records the event.
// - Flags stay set until software clears them before re-enabling.
// - Enable and return instructions set global enable; disable clears it.
// - Host resume may only vector while the slow dual-clock mode runs.
// - Clearing run stops oscillator; resume, watchdog or port change wakes.
// - Wake by resume continues after sleep and sets resume wake flag.
// - Clearing dual clock select runs slow oscillator; two bits pick speed.
// - Pattern enable starts detection and forces both pattern pins to input.
// - Mask bits 0 to 7 enable their sources in the status bit order.
`timescale 1ns/1ps
`default_nettype none
`include "iwu_consts.svh"

// ****************************************************************
// Pattern channel event watcher
// ****************************************************************
module iwu_pattern_chan (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Channel input and count
    input wire logic enable_i,
    input wire logic level_i,
    input wire logic [7:0] count_i,
    // Thresholds
    input wire logic [7:0] low_threshold_i,
    input wire logic [7:0] high_threshold_i,
    // Event
    output logic event_o
);
    import iwu_pkg::*;

    iwu_chan_t st;
    iwu_chan_t next_st;
    // Edge flags of this cycle
    logic fell;
    logic rose;
    logic steady;

    // Edge and saturation detection
    always_comb
    begin
        next_st = st;
        next_st.prev_level = level_i;
        next_st.prev_count = count_i;
        next_st.primed = enable_i;
        // Only armed once a previous sample exists, else enabling looks like an edge
        fell = st.primed && enable_i && st.prev_level && !level_i;
        rose = st.primed && enable_i && !st.prev_level && level_i;
        steady = st.primed && enable_i && (st.prev_level == level_i);
        event_o = 1'b0;
        // A high pattern ends on a fall; a low pattern ends on a rise
        // Strict compare: a count equal to the threshold does not fire
        if (fell && (count_i > high_threshold_i))
        begin
            event_o = 1'b1;
        end
        if (rose && (count_i > low_threshold_i))
        begin
            event_o = 1'b1;
        end
        // Fire once when the count first reaches saturation
        if (steady && (count_i == `IWU_SAT_COUNT) && (st.prev_count != `IWU_SAT_COUNT))
        begin
            event_o = 1'b1;
        end
    end

    // State register
    // Reset unprimes the watcher so enabling never fakes an edge
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

endmodule : iwu_pattern_chan

// ****************************************************************
// Top level
// ****************************************************************
module iwu_wake_unit (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register port
    input wire iwu_pkg::iwu_addr_t reg_addr_i,
    input wire iwu_pkg::iwu_byte_t reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output iwu_pkg::iwu_byte_t reg_rdata_o,
    // Event sources
    input wire logic timer_overflow_i,
    input wire logic [7:0] port7_level_i,
    input wire logic ep0_setup_i,
    input wire logic usb_suspend_i,
    input wire logic usb_reset_i,
    input wire logic bus_resume_i,
    input wire logic device_resume_i,
    input wire logic watchdog_reset_i,
    // Pattern channels
    input wire logic ch1_level_i,
    input wire logic [7:0] ch1_count_i,
    input wire logic ch2_level_i,
    input wire logic [7:0] ch2_count_i,
    // Core instructions
    input wire logic enable_irq_instr_i,
    input wire logic disable_irq_instr_i,
    input wire logic return_irq_instr_i,
    // Core vectoring
    output logic vector_req_o,
    output iwu_pkg::iwu_pc_t vector_addr_o,
    // Clock and pin control
    output logic core_clock_enable_o,
    output logic ext_osc_enable_o,
    output logic slow_osc_select_o,
    output logic [1:0] slow_freq_select_o,
    output logic pattern_pins_input_o,
    output logic global_irq_enable_o
);
    import iwu_pkg::*;

    iwu_state_t st;
    iwu_state_t next_st;
    logic ch1_event;
    logic ch2_event;
    // Raw events of this cycle, before masking
    logic [7:0] set_bits;
    logic [7:0] pending;
    logic port7_change;
    logic wake_event;
    logic take;

    // ****************************************************************
    // Pattern channel watchers
    // ****************************************************************
    // Both channels share one enable and identical logic
    iwu_pattern_chan u_ch1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .enable_i(st.pat_en),
        .level_i(ch1_level_i),
        .count_i(ch1_count_i),
        .low_threshold_i(st.ch1_lo),
        .high_threshold_i(st.ch1_hi),
        .event_o(ch1_event)
    );

    iwu_pattern_chan u_ch2 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .enable_i(st.pat_en),
        .level_i(ch2_level_i),
        .count_i(ch2_count_i),
        .low_threshold_i(st.ch2_lo),
        .high_threshold_i(st.ch2_hi),
        .event_o(ch2_event)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        next_st = st;
        next_st.vec_req = 1'b0;
        next_st.rdata = `IWU_ZERO8;
        next_st.port7_prev = port7_level_i;
        next_st.port7_primed = 1'b1;

        // Gather this cycle's events
        // The first sample after reset counts as no change
        port7_change = st.port7_primed && (port7_level_i != st.port7_prev);
        set_bits = `IWU_ZERO8;
        set_bits[`IWU_BIT_TIMER] = timer_overflow_i;
        set_bits[`IWU_BIT_EP0] = ep0_setup_i;
        set_bits[`IWU_BIT_SUSPEND] = usb_suspend_i;
        set_bits[`IWU_BIT_USB_RESET] = usb_reset_i;
        set_bits[`IWU_BIT_PORT7] = port7_change;
        set_bits[`IWU_BIT_CH1] = ch1_event;
        set_bits[`IWU_BIT_CH2] = ch2_event;
        set_bits[`IWU_BIT_HOST_RESUME] = bus_resume_i && !device_resume_i;

        // Software writes: zero clears a flag, one leaves it alone
        if (reg_write_i)
        begin
            unique case (reg_addr_i)
                `IWU_OFS_FLAGS: next_st.flags = st.flags & reg_wdata_i;
                `IWU_OFS_MASK: next_st.mask = reg_wdata_i;
                `IWU_OFS_POWER:
                begin
                    next_st.run = reg_wdata_i[`IWU_BIT_RUN];
                    next_st.dual_clk = reg_wdata_i[`IWU_BIT_DUAL_CLK];
                end
                `IWU_OFS_OSC:
                begin
                    next_st.pat_en = reg_wdata_i[`IWU_BIT_PAT_EN];
                    next_st.slow_freq = reg_wdata_i[`IWU_BIT_SLOW_HI:`IWU_BIT_SLOW_LO];
                end
                `IWU_OFS_WAKE:
                begin
                    next_st.resume_wake = st.resume_wake && reg_wdata_i[`IWU_BIT_RESUME_WAKE];
                end
                `IWU_OFS_CH1_LO: next_st.ch1_lo = reg_wdata_i;
                `IWU_OFS_CH1_HI: next_st.ch1_hi = reg_wdata_i;
                `IWU_OFS_CH2_LO: next_st.ch2_lo = reg_wdata_i;
                `IWU_OFS_CH2_HI: next_st.ch2_hi = reg_wdata_i;
                default:
                begin
                    // Unmapped writes are ignored
                end
            endcase
        end

        // Flags record every event regardless of mask; set beats a clear
        next_st.flags = next_st.flags | set_bits;

        // Wake from power-down; a watchdog wake also restarts the clock
        // Checked after writes, so while asleep a wake beats a same-cycle sleep write; while running the sleep write wins
        wake_event = bus_resume_i || watchdog_reset_i || port7_change;
        if (!st.run && wake_event)
        begin
            next_st.run = 1'b1;
            if (bus_resume_i)
            begin
                next_st.resume_wake = 1'b1;
            end
        end

        // Masked pending sources; host resume only counts in slow clock mode
        pending = st.flags & st.mask;
        if (st.dual_clk)
        begin
            pending[`IWU_BIT_HOST_RESUME] = 1'b0;
        end

        // Global enable from instructions; disable wins over enable
        // Return sets it too, re-arming after the service routine
        if (enable_irq_instr_i || return_irq_instr_i)
        begin
            next_st.gie = 1'b1;
        end
        if (disable_irq_instr_i)
        begin
            next_st.gie = 1'b0;
        end

        // One request for any number of pending sources; entry drops the enable
        // A standing request blocks a second take in the following cycle
        take = st.run && st.gie && (|pending) && !st.vec_req;
        if (take)
        begin
            next_st.vec_req = 1'b1;
            next_st.vec_addr = `IWU_VECTOR_ADDR;
            next_st.gie = 1'b0;
        end

        // Read data for the next cycle; unmapped reads return zero
        // The data stand one cycle; the default above zeroes them after
        if (reg_read_i)
        begin
            unique case (reg_addr_i)
                `IWU_OFS_FLAGS: next_st.rdata = st.flags;
                `IWU_OFS_MASK: next_st.rdata = st.mask;
                `IWU_OFS_POWER:
                begin
                    next_st.rdata[`IWU_BIT_RUN] = st.run;
                    next_st.rdata[`IWU_BIT_DUAL_CLK] = st.dual_clk;
                end
                `IWU_OFS_OSC:
                begin
                    next_st.rdata[`IWU_BIT_PAT_EN] = st.pat_en;
                    next_st.rdata[`IWU_BIT_SLOW_HI:`IWU_BIT_SLOW_LO] = st.slow_freq;
                end
                `IWU_OFS_WAKE: next_st.rdata[`IWU_BIT_RESUME_WAKE] = st.resume_wake;
                `IWU_OFS_CH1_LO: next_st.rdata = st.ch1_lo;
                `IWU_OFS_CH1_HI: next_st.rdata = st.ch1_hi;
                `IWU_OFS_CH2_LO: next_st.rdata = st.ch2_lo;
                `IWU_OFS_CH2_HI: next_st.rdata = st.ch2_hi;
                default: next_st.rdata = `IWU_ZERO8;
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st <= '0;
            // Run and the normal clock are on from reset
            st.mask <= `IWU_RESET_MASK;
            st.run <= `IWU_RESET_RUN;
            st.dual_clk <= `IWU_RESET_DUAL_CLK;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // The clock gate follows run; the slow oscillator replaces the external one
    // Register port and vectoring
    assign reg_rdata_o = st.rdata;
    assign vector_req_o = st.vec_req;
    assign vector_addr_o = st.vec_addr;
    // Clock gating and oscillator choice
    assign core_clock_enable_o = st.run;
    assign ext_osc_enable_o = st.run && st.dual_clk;
    assign slow_osc_select_o = !st.dual_clk;
    assign slow_freq_select_o = st.slow_freq;
    // Pin direction and global enable
    assign pattern_pins_input_o = st.pat_en;
    assign global_irq_enable_o = st.gie;

endmodule : iwu_wake_unit
`default_nettype wire

// *** test/iwu_wake_unit_checker.sv ***
// Port-level assertions for the interrupt and wake unit
`timescale 1ns/1ps
`default_nettype none
module iwu_wake_unit_checker (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Inputs watched
    input wire iwu_pkg::iwu_addr_t reg_addr_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    input wire logic timer_overflow_i,
    input wire logic bus_resume_i,
    input wire logic watchdog_reset_i,
    input wire logic enable_irq_instr_i,
    input wire logic disable_irq_instr_i,
    input wire logic return_irq_instr_i,
    // Outputs watched
    input wire iwu_pkg::iwu_byte_t reg_rdata_o,
    input wire logic vector_req_o,
    input wire iwu_pkg::iwu_pc_t vector_addr_o,
    input wire logic core_clock_enable_o,
    input wire logic ext_osc_enable_o,
    input wire logic slow_osc_select_o,
    input wire logic global_irq_enable_o
);
    import iwu_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Timer event, a quiet cycle with no clearing write, then a flag read
    sequence timer_then_read;
        timer_overflow_i ##1 !reg_write_i ##1 (reg_read_i && reg_addr_i == 8'h00);
    endsequence
    // Asleep while a resume or watchdog wake arrives
    sequence asleep_wake;
        !core_clock_enable_o && (bus_resume_i || watchdog_reset_i);
    endsequence
    chk_vector_addr: assert property (vector_req_o |-> vector_addr_o == 13'h0001)
        else $error("vector address is not the single vector");
    chk_timer_flag: assert property (timer_then_read |=> reg_rdata_o[0])
        else $error("timer overflow flag not read back");
    chk_single_req: assert property (vector_req_o |=> !vector_req_o)
        else $error("vector request longer than one cycle");
    chk_take_gie: assert property (vector_req_o |-> $past(global_irq_enable_o)
        && !global_irq_enable_o)
        else $error("vector without global enable or enable kept");
    chk_disable_gie: assert property (disable_irq_instr_i |=> !global_irq_enable_o)
        else $error("disable instruction left global enable set");
    chk_enable_gie: assert property ((enable_irq_instr_i || return_irq_instr_i)
        && !disable_irq_instr_i && !global_irq_enable_o |=> global_irq_enable_o)
        else $error("enable or return did not set global enable");
    chk_asleep_novec: assert property (vector_req_o |-> $past(core_clock_enable_o))
        else $error("vector taken while asleep");
    chk_wake_run: assert property (asleep_wake |=> core_clock_enable_o)
        else $error("wake source did not restart the clock");
    chk_osc_pair: assert property (ext_osc_enable_o ==
        (core_clock_enable_o && !slow_osc_select_o))
        else $error("external oscillator enable inconsistent");
endmodule : iwu_wake_unit_checker
`default_nettype wire

// *** test/iwu_core_model.sv ***
// Core model: returns from service a set number of cycles after each vector
`timescale 1ns/1ps
`default_nettype none
module iwu_core_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Vector and service time
    input wire logic vector_req_i,
    input wire logic [7:0] delay_i,
    // Return instruction
    output logic return_o
);
    logic [7:0] left;
    logic busy;
    // Count the service time down, then one return pulse
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            left <= 8'h00;
            busy <= 1'b0;
            return_o <= 1'b0;
        end
        else
        begin
            return_o <= busy && left == 8'h00;
            if (vector_req_i)
            begin
                busy <= 1'b1;
                left <= delay_i;
            end
            else if (busy)
            begin
                left <= left - 8'h01;
                busy <= left != 8'h00;
            end
        end
    end
endmodule : iwu_core_model
`default_nettype wire

// *** test/iwu_wake_unit_test.sv ***
// Self-checking bench of the interrupt and wake unit
`timescale 1ns/1ps
`default_nettype none
module iwu_wake_unit_test;
    import iwu_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, reg_write_i = 1'b0, reg_read_i = 1'b0;
    iwu_addr_t reg_addr_i = 8'h00;
    iwu_byte_t reg_wdata_i = 8'h00, reg_rdata_o, d, m, src;
    logic timer_overflow_i = 1'b0, ep0_setup_i = 1'b0, usb_suspend_i = 1'b0, usb_reset_i = 1'b0;
    logic bus_resume_i = 1'b0, device_resume_i = 1'b0, watchdog_reset_i = 1'b0;
    logic ch1_level_i = 1'b0, ch2_level_i = 1'b0, enable_irq_instr_i = 1'b0;
    logic disable_irq_instr_i = 1'b0, return_irq_instr_i, seen;
    logic [7:0] port7_level_i = 8'h00, ch1_count_i = 8'h00, ch2_count_i = 8'h00, svc_delay = 8'd12;
    iwu_pc_t vector_addr_o;
    logic vector_req_o, core_clock_enable_o, ext_osc_enable_o, slow_osc_select_o;
    logic pattern_pins_input_o, global_irq_enable_o;
    logic [1:0] slow_freq_select_o;
    int errors = 0, n_compared = 0, n_vec = 0, nexp = 0;
    integer seed = 32'h4ab61693;

    always #5 clk_i = ~clk_i;
    // Vector pulses seen, to catch a second request from a stale flag
    always @(posedge clk_i) if (vector_req_o === 1'b1) n_vec <= n_vec + 1;

    iwu_wake_unit dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
        .timer_overflow_i(timer_overflow_i), .port7_level_i(port7_level_i),
        .ep0_setup_i(ep0_setup_i), .usb_suspend_i(usb_suspend_i), .usb_reset_i(usb_reset_i),
        .bus_resume_i(bus_resume_i), .device_resume_i(device_resume_i),
        .watchdog_reset_i(watchdog_reset_i), .ch1_level_i(ch1_level_i), .ch1_count_i(ch1_count_i),
        .ch2_level_i(ch2_level_i), .ch2_count_i(ch2_count_i),
        .enable_irq_instr_i(enable_irq_instr_i), .disable_irq_instr_i(disable_irq_instr_i),
        .return_irq_instr_i(return_irq_instr_i), .vector_req_o(vector_req_o),
        .vector_addr_o(vector_addr_o), .core_clock_enable_o(core_clock_enable_o),
        .ext_osc_enable_o(ext_osc_enable_o), .slow_osc_select_o(slow_osc_select_o),
        .slow_freq_select_o(slow_freq_select_o), .pattern_pins_input_o(pattern_pins_input_o),
        .global_irq_enable_o(global_irq_enable_o));
    iwu_core_model core_u (.clk_i(clk_i), .rst_i(rst_i), .vector_req_i(vector_req_o),
        .delay_i(svc_delay), .return_o(return_irq_instr_i));

    task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic close_out;
        $display("Compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    task automatic reg_wr(input iwu_addr_t a, input iwu_byte_t v);
        @(posedge clk_i);
        {reg_addr_i, reg_wdata_i, reg_write_i} <= {a, v, 1'b1};
        @(posedge clk_i);
        reg_write_i <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input iwu_addr_t a, output iwu_byte_t v);
        @(posedge clk_i);
        {reg_addr_i, reg_read_i} <= {a, 1'b1};
        @(posedge clk_i);
        reg_read_i <= 1'b0;
        #1 v = reg_rdata_o;
    endtask : reg_rd
    // Read the flags, clear them by writing zero, confirm the clear
    task automatic flags_is(input iwu_byte_t e);
        reg_rd(8'h00, d);
        check("flags", d, e);
        reg_wr(8'h00, 8'h00);
        reg_rd(8'h00, d);
        check("flags cleared", d, 8'h00);
    endtask : flags_is
    // One-cycle event pulses; bit 4 toggles random port 7 pins, bit 5 is the watchdog
    task automatic pulse(input iwu_byte_t b);
        @(posedge clk_i);
        {timer_overflow_i, ep0_setup_i, usb_suspend_i, usb_reset_i} <= {b[0], b[1], b[2], b[3]};
        {watchdog_reset_i, bus_resume_i} <= {b[5], b[7]};
        if (b[4]) port7_level_i <= port7_level_i ^ (8'($random(seed)) | 8'h01);
        @(posedge clk_i);
        {timer_overflow_i, ep0_setup_i, usb_suspend_i, usb_reset_i} <= 4'h0;
        {watchdog_reset_i, bus_resume_i} <= 2'b00;
    endtask : pulse
    task automatic set_ch(input int c, input logic lv, input logic [7:0] cnt);
        @(posedge clk_i);
        if (c == 0) {ch1_level_i, ch1_count_i} <= {lv, cnt};
        else {ch2_level_i, ch2_count_i} <= {lv, cnt};
    endtask : set_ch
    task automatic wait_vec(output logic s);
        s = 1'b0;
        repeat (4)
        begin
            @(posedge clk_i);
            #1 if (vector_req_o === 1'b1) s = 1'b1;
        end
    endtask : wait_vec

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clk_i);
        errors++;
        close_out();
    end

    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        #1 check("gie", global_irq_enable_o, 0);
        check("run ext", {core_clock_enable_o, ext_osc_enable_o}, 2'b11);
        check("slow sel", slow_osc_select_o, 1'b0);
        reg_rd(8'h01, d);
        check("mask", d, 8'h00);
        // Every source but the two pattern channels sets its own flag even while masked and disabled
        for (int b = 0; b < 8; b++)
            if (b != 5 && b != 6)
            begin
                pulse(8'(8'h01 << b));
                flags_is(8'(8'h01 << b));
            end
        @(posedge clk_i) device_resume_i <= 1'b1;
        pulse(8'h80);
        flags_is(8'h00);
        @(posedge clk_i) device_resume_i <= 1'b0;
        // An event in the cycle of a clearing write still lands
        pulse(8'h02);
        @(posedge clk_i) {reg_addr_i, reg_wdata_i} <= 16'h0000;
        {reg_write_i, timer_overflow_i} <= 2'b11;
        @(posedge clk_i) {reg_write_i, timer_overflow_i} <= 2'b00;
        flags_is(8'h01);
        // Pattern channels: fall above high, rise at the low boundary, saturation
        reg_wr(8'h03, 8'h04);
        #1 check("pins", pattern_pins_input_o, 1);
        for (int c = 0; c < 2; c++)
        begin
            reg_wr(8'h10 + 8'(2 * c), 8'h10);
            reg_wr(8'h11 + 8'(2 * c), 8'h20);
            set_ch(c, 1'b1, 8'h05);
            set_ch(c, 1'b0, 8'h21);
            flags_is(8'(8'h20 << c));
            set_ch(c, 1'b1, 8'h10);
            flags_is(8'h00);
            set_ch(c, 1'b1, 8'hfe);
            set_ch(c, 1'b1, 8'hff);
            flags_is(8'(8'h20 << c));
        end
        // Random masks and source sets with the core model returning fast or slow
        for (int i = 0; i < 12; i++)
        begin
            m = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
            src = (i < 2) ? 8'h1f : 8'($random(seed)) & 8'h1f | 8'h01;
            svc_delay <= i[0] ? 8'd40 : 8'd12;
            reg_wr(8'h01, m);
            @(posedge clk_i) enable_irq_instr_i <= 1'b1;
            @(posedge clk_i) enable_irq_instr_i <= 1'b0;
            pulse(src);
            wait_vec(seen);
            check("vector", seen, |(src & m));
            nexp += int'(|(src & m));
            flags_is(src);
            repeat (50) @(posedge clk_i);
            #1 check("gie", global_irq_enable_o, 1);
        end
        // Host resume waits for the slow clock mode
        reg_wr(8'h01, 8'hff);
        pulse(8'h80);
        wait_vec(seen);
        check("resume vector", seen, 0);
        reg_wr(8'h02, 8'h10);
        #1 check("run ext", {core_clock_enable_o, ext_osc_enable_o}, 2'b10);
        check("slow sel", slow_osc_select_o, 1'b1);
        wait_vec(seen);
        check("resume vector", seen, 1);
        nexp++;
        flags_is(8'h80);
        reg_wr(8'h02, 8'h90);
        reg_wr(8'h03, 8'hc0);
        #1 check("osc", {slow_freq_select_o, pattern_pins_input_o}, 3'b110);
        reg_rd(8'h02, d);
        check("power reg", d, 8'h90);
        reg_rd(8'h03, d);
        check("osc reg", d, 8'hc0);
        repeat (50) @(posedge clk_i);
        @(posedge clk_i) disable_irq_instr_i <= 1'b1;
        @(posedge clk_i) disable_irq_instr_i <= 1'b0;
        #1 check("gie", global_irq_enable_o, 0);
        // Sleep, then each wake source; only bus resume marks the wake
        for (int w = 0; w < 3; w++)
        begin
            reg_wr(8'h02, 8'h80);
            #1 check("asleep", {core_clock_enable_o, ext_osc_enable_o}, 2'b00);
            pulse(w == 0 ? 8'h80 : w == 1 ? 8'h20 : 8'h10);
            #1 check("awake", {core_clock_enable_o, ext_osc_enable_o}, 2'b11);
            reg_rd(8'h04, d);
            check("wake flag", d, w == 0 ? 8'h08 : 8'h00);
            reg_wr(8'h04, 8'h00);
            reg_wr(8'h00, 8'h00);
        end
        check("vector count", 16'(n_vec), 16'(nexp));
        close_out();
    end
endmodule : iwu_wake_unit_test

bind iwu_wake_unit iwu_wake_unit_checker chk_u (.clk_i(clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .timer_overflow_i(timer_overflow_i), .bus_resume_i(bus_resume_i),
    .watchdog_reset_i(watchdog_reset_i), .enable_irq_instr_i(enable_irq_instr_i),
    .disable_irq_instr_i(disable_irq_instr_i), .return_irq_instr_i(return_irq_instr_i),
    .reg_rdata_o(reg_rdata_o), .vector_req_o(vector_req_o), .vector_addr_o(vector_addr_o),
    .core_clock_enable_o(core_clock_enable_o), .ext_osc_enable_o(ext_osc_enable_o),
    .slow_osc_select_o(slow_osc_select_o), .global_irq_enable_o(global_irq_enable_o));
`default_nettype wire
